// [core/dcp_edge_sync.sv]
// three-stage pin synchroniser with rising and falling event pulses
module dcp_edge_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic [2:0] sync;
  logic level;
  logic [2:0] next_sync;
  logic next_level;

  always_comb begin
    next_sync = {sync[1:0], pin};
    next_level = level;
    // change counts once the second and third stage agree
    if (sync[1] == sync[2]) begin
      next_level = sync[2];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync <= 3'h0;
      level <= 1'b0;
    end else if (clk_en) begin
      sync <= next_sync;
      level <= next_level;
    end
  end

  assign rise = clk_en && next_level && !level;
  assign fall = clk_en && !next_level && level;
endmodule

// [core/dcp_pkg.sv]
// shared constants and types for the down-counter pwm unit
package dcp_pkg;
  // register indices as printed; byte address is index times four
  localparam logic [3:0] IDX_COUNT = 4'h9;
  localparam logic [3:0] IDX_CTRL1 = 4'ha;
  localparam logic [3:0] IDX_CTRL2 = 4'hb;
  localparam logic [3:0] IDX_DUTY = 4'hc;
  localparam logic [7:0] ADDR_COUNT = {2'h0, IDX_COUNT, 2'h0};
  localparam logic [7:0] ADDR_CTRL1 = {2'h0, IDX_CTRL1, 2'h0};
  localparam logic [7:0] ADDR_CTRL2 = {2'h0, IDX_CTRL2, 2'h0};
  localparam logic [7:0] ADDR_DUTY = {2'h0, IDX_DUTY, 2'h0};
  // control one bit positions
  localparam int C1_EN = 0;
  localparam int C1_RL = 1;
  localparam int C1_OS = 2;
  localparam int C1_POL = 6;
  localparam int C1_OE = 7;
  // control two bit positions
  localparam int C2_RATE_LO = 0;
  localparam int C2_PSDIS_N = 3;
  localparam int C2_EDGE = 4;
  localparam int C2_SRC = 5;
  // reset values and other fixed constants
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h3f;
  localparam logic [7:0] COUNT_RST = 8'hff;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] PRESC_RST = 8'hff;
  localparam logic [7:0] WRAP_VAL = 8'hff;
  localparam logic [7:0] ZERO_VAL = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic pin_en;
    logic polarity;
    logic one_shot;
    logic reload_sel;
    logic enable;
  } dcp_ctrl1_t;

  typedef struct packed {
    logic src_ext;
    logic edge_fall;
    logic presc_dis_n;
    logic [2:0] rate;
  } dcp_ctrl2_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } dcp_state_t;
endpackage

// [core/dcp_prescaler.sv]
// prescaler: 8-bit down counter giving one pulse per 2^(rate+1) events
module dcp_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic event_in,
  input wire logic [2:0] rate,
  output logic tick
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic [WIDTH-1:0] mask;

  // the rate decode and reset value assume an 8-bit divider
  if (WIDTH != 8) begin : g_width_chk
    $error("prescaler width must be 8");
  end

  always_comb begin
    mask = WIDTH'((9'h002 << rate) - 9'h001);
    next_cnt = cnt;
    tick = 1'b0;
    if (!enable) begin
      next_cnt = dcp_pkg::PRESC_RST;
    end else if (event_in) begin
      next_cnt = cnt - WIDTH'(1);
      // a full period of the selected ratio has elapsed
      if ((cnt & mask) == WIDTH'(0)) begin
        tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= dcp_pkg::PRESC_RST;
    end else if (clk_en) begin
      cnt <= next_cnt;
    end
  end
endmodule

// [core/dcp_timer.sv]
// down-counting timer with prescaler, pwm stage and ahb-lite slave
//
// Operation
// - a read of the count register returns the live counter value.
// - writing the count register sets both the reload value and the counter.
// - non-stop with reload select clear wraps from zero to 0xff.
// - non-stop with reload select set reloads the stored value on underflow.
// - one-shot counts down to zero once and then stops.
// - the rate field divides by 2 to 256 in doublings; bypassed when disabled.
// - external counting uses falling edges when edge select is 1, else rising.
// - source select 1 picks the external pin, 0 the instruction clock.
// - pwm is inactive until count equals duty, then active until underflow.
// - pwm period follows the reload value with reload select set (else 256 steps), and duty the duty register.
// - polarity bit 1 makes pwm active low, 0 active high.
// - pin enable routes pwm to the port pin, else the pin stays gpio.
// - the duty register is write-only and reads back zero.
module dcp_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_count_pin,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic pwm_port_pin_out,
  output logic pwm_port_pin_oe
);
  dcp_pkg::dcp_ctrl1_t ctrl1, next_ctrl1;
  dcp_pkg::dcp_ctrl2_t ctrl2, next_ctrl2;
  dcp_pkg::dcp_state_t state, next_state;
  logic [7:0] count, next_count;
  logic [7:0] reload, next_reload;
  logic [7:0] duty, next_duty;
  logic pwm_act, next_pwm_act;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic next_pin_out, next_pin_oe;
  logic ext_rise, ext_fall, ext_evt, src_evt, presc_tick, step;
  logic wr_now;
  logic rd_take;
  logic [7:0] rd_addr;
  logic underflow;

  dcp_edge_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin(external_count_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  assign ext_evt = ctrl2.edge_fall ? ext_fall : ext_rise;
  // instruction clock: one event per enabled clock cycle
  assign src_evt = ctrl2.src_ext ? ext_evt : 1'b1;

  dcp_prescaler #(
    .WIDTH(8)
  ) u_presc (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .enable(!ctrl2.presc_dis_n && ctrl1.enable),
    .event_in(src_evt),
    .rate(ctrl2.rate),
    .tick(presc_tick)
  );

  // prescaler bypassed while its disable bit is set
  assign step = ctrl1.enable &&
                (ctrl2.presc_dis_n ? src_evt : presc_tick);

  // bus: address phase capture
  assign wr_now = hsel && hready && htrans[1] && hwrite;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign rd_addr = haddr[7:0];
  assign underflow = step && (state == dcp_pkg::ST_RUN) &&
                     (count == dcp_pkg::ZERO_VAL);

  always_comb begin
    next_wr_pend = wr_now;
    next_wr_addr = wr_now ? haddr[7:0] : wr_addr;
    next_hrdata = 32'h0;
    if (rd_take) begin
      case (rd_addr)
        dcp_pkg::ADDR_COUNT: next_hrdata = {24'h0, count};
        dcp_pkg::ADDR_CTRL1: next_hrdata = {24'h0, 5'h0, ctrl1.one_shot,
                                            ctrl1.reload_sel, ctrl1.enable};
        dcp_pkg::ADDR_CTRL2: next_hrdata = {24'h0, 2'h0, ctrl2};
        dcp_pkg::ADDR_DUTY: next_hrdata = 32'h0;
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  always_comb begin
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    next_reload = reload;
    next_duty = duty;
    next_count = count;
    next_state = state;
    next_pwm_act = pwm_act;
    case (state)
      dcp_pkg::ST_IDLE: begin
        next_pwm_act = 1'b0;
        if (ctrl1.enable) begin
          next_state = dcp_pkg::ST_RUN;
        end
      end
      dcp_pkg::ST_RUN: begin
        if (!ctrl1.enable) begin
          next_state = dcp_pkg::ST_IDLE;
        end else if (underflow) begin
          next_pwm_act = 1'b0;
          if (ctrl1.one_shot) begin
            next_state = dcp_pkg::ST_DONE;
          end else if (ctrl1.reload_sel) begin
            next_count = reload;
          end else begin
            next_count = dcp_pkg::WRAP_VAL;
          end
        end else if (step) begin
          next_count = count - 8'h01;
        end
        if (ctrl1.enable && !underflow && count == duty) begin
          next_pwm_act = 1'b1;
        end
      end
      dcp_pkg::ST_DONE: begin
        next_pwm_act = 1'b0;
        if (!ctrl1.enable) begin
          next_state = dcp_pkg::ST_IDLE;
        end
      end
      default: next_state = dcp_pkg::ST_IDLE;
    endcase
    if (wr_pend) begin
      case (wr_addr)
        dcp_pkg::ADDR_COUNT: begin
          next_reload = hwdata[7:0];
          next_count = hwdata[7:0];
          if (state == dcp_pkg::ST_DONE) begin
            next_state = dcp_pkg::ST_RUN;
          end
        end
        dcp_pkg::ADDR_CTRL1: begin
          next_ctrl1.pin_en = hwdata[dcp_pkg::C1_OE];
          next_ctrl1.polarity = hwdata[dcp_pkg::C1_POL];
          next_ctrl1.one_shot = hwdata[dcp_pkg::C1_OS];
          next_ctrl1.reload_sel = hwdata[dcp_pkg::C1_RL];
          next_ctrl1.enable = hwdata[dcp_pkg::C1_EN];
        end
        dcp_pkg::ADDR_CTRL2: begin
          next_ctrl2 = hwdata[dcp_pkg::C2_SRC:dcp_pkg::C2_RATE_LO];
        end
        dcp_pkg::ADDR_DUTY: next_duty = hwdata[7:0];
        default: next_duty = duty;
      endcase
    end
  end

  always_comb begin
    // polarity applied, then pin mux
    next_pin_out = gpio_out;
    next_pin_oe = gpio_oe;
    if (ctrl1.pin_en) begin
      next_pin_out = next_pwm_act ^ next_ctrl1.polarity;
      next_pin_oe = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1 <= dcp_pkg::dcp_ctrl1_t'(5'h0);
      ctrl2 <= dcp_pkg::dcp_ctrl2_t'(dcp_pkg::CTRL2_RST[5:0]);
      state <= dcp_pkg::ST_IDLE;
      count <= dcp_pkg::COUNT_RST;
      reload <= dcp_pkg::COUNT_RST;
      duty <= dcp_pkg::DUTY_RST;
      pwm_act <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0;
      pwm_port_pin_out <= 1'b0;
      pwm_port_pin_oe <= 1'b0;
    end else if (clk_en) begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
      state <= next_state;
      count <= next_count;
      reload <= next_reload;
      duty <= next_duty;
      pwm_act <= next_pwm_act;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      pwm_port_pin_out <= next_pin_out;
      pwm_port_pin_oe <= next_pin_oe;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  property wrap_p;
    @(posedge clk) disable iff (!reset_n)
    clk_en && underflow && ctrl1.enable && !ctrl1.one_shot &&
    !ctrl1.reload_sel && !wr_pend |=> count == 8'hff;
  endproperty
  wrap_to_ff_a: assert property (wrap_p)
    else $error("counter did not wrap to 0xff");

  reload_on_uf_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    clk_en && underflow && ctrl1.enable && !ctrl1.one_shot &&
    ctrl1.reload_sel && !wr_pend |=> count == $past(reload))
    else $error("counter did not reload");

  one_shot_stop_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    clk_en && underflow && ctrl1.enable && ctrl1.one_shot && !wr_pend
    |=> state == dcp_pkg::ST_DONE)
    else $error("one-shot did not stop");

  count_write_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    clk_en && wr_pend && wr_addr == dcp_pkg::ADDR_COUNT
    |=> count == $past(hwdata[7:0]) && reload == $past(hwdata[7:0]))
    else $error("count write not applied");

  hold_disabled_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    clk_en && !ctrl1.enable && !wr_pend |=> count == $past(count))
    else $error("counter moved while disabled");

  sequence match_s;
    clk_en && state == dcp_pkg::ST_RUN && ctrl1.enable && !underflow &&
    count == duty;
  endsequence
  pwm_goes_act_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    match_s |=> pwm_act)
    else $error("pwm not active after match");

  pwm_off_uf_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    clk_en && underflow && ctrl1.enable |=> !pwm_act)
    else $error("pwm not cleared on underflow");

  pin_polarity_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    clk_en && ctrl1.pin_en |=> pwm_port_pin_oe &&
    pwm_port_pin_out == (pwm_act ^ ctrl1.polarity))
    else $error("pwm pin level wrong");

  duty_reads_zero_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    clk_en && rd_take && rd_addr == dcp_pkg::ADDR_DUTY |=> hrdata == 32'h0)
    else $error("duty register readable");

  sequence run_quiet_s;
    clk_en && state == dcp_pkg::ST_RUN && ctrl1.enable && !wr_pend &&
    count != dcp_pkg::ZERO_VAL;
  endsequence

  bypass_step_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    run_quiet_s ##0 (!ctrl2.src_ext && ctrl2.presc_dis_n)
    |=> count == $past(count) - 8'h01)
    else $error("bypassed counter did not step");

  ext_edge_step_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    run_quiet_s ##0 (ctrl2.src_ext && ctrl2.presc_dis_n &&
    (ctrl2.edge_fall ? ext_fall : ext_rise))
    |=> count == $past(count) - 8'h01)
    else $error("selected pin edge not counted");

  ext_edge_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    run_quiet_s ##0 (ctrl2.src_ext && ctrl2.presc_dis_n &&
    !(ctrl2.edge_fall ? ext_fall : ext_rise))
    |=> count == $past(count))
    else $error("counter moved without selected edge");

  cen_freeze_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !clk_en |=> count == $past(count) && state == $past(state) &&
    pwm_act == $past(pwm_act))
    else $error("state moved while clock enable low");

  pwm_idle_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    clk_en && state != dcp_pkg::ST_RUN |=> !pwm_act)
    else $error("pwm active while not counting");
endmodule

// [test/dcp_far_model.sv]
// far-side model: external count pin driver and pwm pin meter
module dcp_far_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic toggle,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic ext_pin,
  output logic [11:0] period,
  output logic [11:0] high_w
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  logic pin;
  logic [11:0] cnt;
  logic [11:0] hcnt;
  assign pin = pin_oe & pin_out;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_pin <= 1'b0;
      prev <= 1'b0;
      cnt <= 12'h0;
      hcnt <= 12'h0;
      period <= 12'h0;
      high_w <= 12'h0;
    end else begin
      // one edge per request; the bench keeps levels at least 5 cycles
      if (toggle) ext_pin <= ~ext_pin;
      prev <= pin;
      // period and high time of the last frame, captured at each rise
      if (pin && !prev) begin
        period <= cnt;
        high_w <= hcnt;
        cnt <= 12'h1;
        hcnt <= 12'h1;
      end else begin
        cnt <= cnt + 12'h1;
        hcnt <= hcnt + {11'h0, pin};
      end
    end
  end
endmodule

// [test/down_counter_pwm_unit_test.sv]
// self-checking bench for the down-counter pwm unit
module down_counter_pwm_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, tog;
  logic ext_pin, rd_dphase, gpio_out, gpio_oe, pin_out, pin_oe, cen;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] period, high_w, hi_a, hi_b;
  logic [7:0] exp_q[$];
  string name_q[$];
  int n_mismatch, total_checks, cyc;

  assign hready = hreadyout;
  dcp_timer u_dut (.clk(clk), .reset_n(reset_n), .clk_en(cen),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_count_pin(ext_pin),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pwm_port_pin_out(pin_out),
    .pwm_port_pin_oe(pin_oe));
  dcp_far_model u_far (.clk(clk), .reset_n(reset_n), .toggle(tog),
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_pin(ext_pin),
    .period(period), .high_w(high_w));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string nm, input logic [11:0] seen,
                       input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, input logic [7:0] e,
                     input string nm);
    hsel <= 1'b1;
    htrans <= dcp_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rd_dphase <= ~wr;
    if (!wr) begin
      exp_q.push_back(e);
      name_q.push_back(nm);
    end
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd_dphase <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 8'h0, "");
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string nm);
    bus(1'b0, a, 8'h0, e, nm);
  endtask

  // one edge on the external count pin, then time for it to land
  task automatic flip();
    tog <= 1'b1;
    @(posedge clk);
    tog <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  // read results are compared against the oldest note in the data phase
  always @(posedge clk) begin
    cyc++;
    if (rd_dphase === 1'b1 && exp_q.size() > 0) begin
      check(name_q.pop_front(), {4'h0, hrdata[7:0]},
            {4'h0, exp_q.pop_front()});
    end
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    int c;
    logic [2:0] p;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = dcp_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    gpio_out = 1'b0;
    gpio_oe = 1'b0;
    tog = 1'b0;
    cen = 1'b1;
    rd_dphase = 1'b0;
    seed = 32'he803;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(dcp_pkg::ADDR_CTRL1, dcp_pkg::CTRL1_RST, "ctrl1_rst");
    rd(dcp_pkg::ADDR_CTRL2, dcp_pkg::CTRL2_RST, "ctrl2_rst");
    rd(dcp_pkg::ADDR_COUNT, dcp_pkg::COUNT_RST, "count_rst");
    wr(8'h40, 8'haa);
    rd(8'h40, 8'h00, "unmapped");
    wr(dcp_pkg::ADDR_DUTY, 8'h55);
    rd(dcp_pkg::ADDR_DUTY, 8'h00, "duty_wo");
    wr(dcp_pkg::ADDR_CTRL2, 8'h28);
    wr(dcp_pkg::ADDR_COUNT, 8'h40);
    rd(dcp_pkg::ADDR_COUNT, 8'h40, "count_load");
    flip();
    flip();
    rd(dcp_pkg::ADDR_COUNT, 8'h40, "count_idle");
    wr(dcp_pkg::ADDR_CTRL1, 8'h01);
    c = 8'h40;
    for (int e = 0; e < 2; e++) begin
      wr(dcp_pkg::ADDR_CTRL2, {3'h1, e[0], 4'h8});
      for (int k = 0; k < 2; k++) begin
        flip();
        if (ext_pin != e[0]) c = c - 1;
        rd(dcp_pkg::ADDR_COUNT, c[7:0], "ext_edge");
      end
    end
    for (int i = 0; i < 3; i++) begin
      wr(dcp_pkg::ADDR_CTRL1, 8'h00);
      wr(dcp_pkg::ADDR_COUNT, 8'h01);
      wr(dcp_pkg::ADDR_CTRL1, (i == 0) ? 8'h01 : (i == 1) ? 8'h03 : 8'h05);
      flip();
      flip();
      rd(dcp_pkg::ADDR_COUNT, 8'h00, "to_zero");
      flip();
      flip();
      rd(dcp_pkg::ADDR_COUNT, (i == 0) ? 8'hff : (i == 1) ? 8'h01 : 8'h00,
         "underflow");
    end
    wr(dcp_pkg::ADDR_CTRL2, 8'h08);
    wr(dcp_pkg::ADDR_COUNT, 8'h09);
    for (int i = 0; i < 3; i++) begin
      wr(dcp_pkg::ADDR_DUTY, (i == 0) ? 8'h02 : 8'h06);
      wr(dcp_pkg::ADDR_CTRL1, (i == 2) ? 8'hc3 : 8'h83);
      repeat (40) @(posedge clk);
      check("pwm_period", period, 12'd10);
      check("pwm_pin_oe", {11'h0, pin_oe}, 12'h1);
      if (i == 0) hi_a = high_w;
      else if (i == 1) hi_b = high_w;
    end
    check("duty_step", hi_b - hi_a, 12'd4);
    check("polarity", high_w, 12'd10 - hi_b);
    wr(dcp_pkg::ADDR_CTRL1, 8'h00);
    wr(dcp_pkg::ADDR_COUNT, 8'h03);
    wr(dcp_pkg::ADDR_DUTY, 8'h01);
    wr(dcp_pkg::ADDR_CTRL1, 8'h83);
    repeat (20) @(posedge clk);
    check("no_presc", period, 12'd4);
    wr(dcp_pkg::ADDR_COUNT, 8'h80);
    // clock enable low: nothing moves, so the read sees the loaded value
    cen <= 1'b0;
    repeat (20) @(posedge clk);
    cen <= 1'b1;
    rd(dcp_pkg::ADDR_COUNT, 8'h80, "cen_freeze");
    wr(dcp_pkg::ADDR_COUNT, 8'h03);
    p = 3'h0;
    for (int r = 0; r < 8; r++) begin
      // rate only changes while the prescaler is held off
      wr(dcp_pkg::ADDR_CTRL2, {5'h01, p});
      wr(dcp_pkg::ADDR_CTRL2, {5'h01, r[2:0]});
      wr(dcp_pkg::ADDR_CTRL2, {5'h00, r[2:0]});
      p = r[2:0];
      repeat ((12 << (r + 1)) + 20) @(posedge clk);
      check("presc_period", period, 12'(4 << (r + 1)));
    end
    wr(dcp_pkg::ADDR_CTRL1, 8'h00);
    repeat (4) begin
      seed = lfsr(seed);
      wr(dcp_pkg::ADDR_COUNT, seed[15:8]);
      rd(dcp_pkg::ADDR_COUNT, seed[15:8], "rand_count");
      gpio_out <= seed[0];
      gpio_oe <= seed[1];
      repeat (3) @(posedge clk);
      check("gpio_out", {11'h0, pin_out}, {11'h0, seed[0]});
      check("gpio_oe", {11'h0, pin_oe}, {11'h0, seed[1]});
    end
    check("hresp", {11'h0, hresp}, 12'h0);
    check("hreadyout", {11'h0, hreadyout}, 12'h1);
    @(posedge clk);
    end_sim();
  end
endmodule
